// [quad_dac_host_ctrl.sv]
/*
  Controller end: Avalon-MM slave with command registers that
  drives the serial frame, parallel write and strobe pins.
  Assumes one master; the link clock is made here by a divider.
*/
// The Avalon-MM register port and the register offsets were decided locally.
module quad_dac_host_ctrl (
  // Core clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Link to the converter
  quad_dac_link_if.host link
);

  // ***********************************************************
  // State
  // ***********************************************************
  quad_dac_pkg::host_s st_reg;
  quad_dac_pkg::host_s st_next;
  logic busy;
  logic cmdWrite;
  logic wrTake;
  logic halfDone;

  // Bus handshake; command writes stall while a transfer runs
  always_comb begin
    busy = (st_reg.state != quad_dac_pkg::H_IDLE);
    cmdWrite = write && (address == quad_dac_pkg::REG_SER_WORD
      || address == quad_dac_pkg::REG_PAR_WORD);
    waitrequest = !ce || (read && !st_reg.rdDone) || (cmdWrite && busy);
    wrTake = write && !waitrequest;
    halfDone = (st_reg.cnt == 4'h0);
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    st_next = st_reg;
    // Half-period counter reloads itself in every state, idle included
    st_next.cnt = halfDone ? quad_dac_pkg::HALF_M1 : st_reg.cnt - 4'h1;

    // Reads take one wait cycle so read data comes from a register
    st_next.rdDone = read && !st_reg.rdDone;
    if (read && !st_reg.rdDone) begin
      case (address)
        quad_dac_pkg::REG_PIN_CTRL: st_next.rdData = {28'h0, st_reg.pinCtrl};
        quad_dac_pkg::REG_STATUS: st_next.rdData = {31'h0, busy};
        default: st_next.rdData = 32'h0000_0000;
      endcase
    end
    if (wrTake && address == quad_dac_pkg::REG_PIN_CTRL) begin
      st_next.pinCtrl = writedata[3:0];
    end

    case (st_reg.state)
      quad_dac_pkg::H_IDLE: begin
        if (wrTake && address == quad_dac_pkg::REG_SER_WORD) begin
          // MSB goes out first
          st_next.word = writedata[11:0]; // RULE9
          st_next.sdi = writedata[11];
          st_next.csN = 1'b0;
          st_next.sclk = 1'b0;
          st_next.bitsLeft = quad_dac_pkg::LAST_BIT; // RULE18
          st_next.cnt = quad_dac_pkg::HALF_M1;
          st_next.state = quad_dac_pkg::H_SER_LO;
        end else if (wrTake && address == quad_dac_pkg::REG_PAR_WORD) begin
          st_next.addrHi = writedata[9];
          st_next.addrLo = writedata[8];
          st_next.parData = writedata[7:0];
          st_next.cnt = quad_dac_pkg::HALF_M1;
          st_next.state = quad_dac_pkg::H_PAR_SET;
        end
      end
      quad_dac_pkg::H_SER_LO: begin
        if (halfDone) begin
          st_next.sclk = 1'b1; // RULE8
          st_next.state = quad_dac_pkg::H_SER_HI;
        end
      end
      quad_dac_pkg::H_SER_HI: begin
        if (halfDone) begin
          st_next.sclk = 1'b0;
          if (st_reg.bitsLeft == 4'h0) begin
            st_next.state = quad_dac_pkg::H_SER_END;
          end else begin
            st_next.word = {st_reg.word[10:0], 1'b0};
            st_next.sdi = st_reg.word[10];
            st_next.bitsLeft = st_reg.bitsLeft - 4'h1;
            st_next.state = quad_dac_pkg::H_SER_LO;
          end
        end
      end
      quad_dac_pkg::H_SER_END: begin
        // Raise chip select, then keep it high a half period
        if (halfDone && !st_reg.csN) begin
          st_next.csN = 1'b1;
        end else if (halfDone) begin
          st_next.state = quad_dac_pkg::H_IDLE;
        end
      end
      quad_dac_pkg::H_PAR_SET: begin
        if (halfDone) begin
          st_next.wrN = 1'b0; // RULE13
          st_next.state = quad_dac_pkg::H_PAR_WR;
        end
      end
      quad_dac_pkg::H_PAR_WR: begin
        if (halfDone) begin
          st_next.wrN = 1'b1;
          st_next.state = quad_dac_pkg::H_PAR_HOLD;
        end
      end
      quad_dac_pkg::H_PAR_HOLD: begin
        if (halfDone) begin
          st_next.state = quad_dac_pkg::H_IDLE;
        end
      end
      default: st_next.state = quad_dac_pkg::H_IDLE;
    endcase

    // Strobe levels and floats; a line floats only between transfers
    st_next.loadN = st_next.pinCtrl[quad_dac_pkg::LOAD_POS];
    st_next.clearN = st_next.pinCtrl[quad_dac_pkg::CLEAR_POS];
    st_next.sdiOe = !(st_next.state == quad_dac_pkg::H_IDLE
      && st_next.pinCtrl[quad_dac_pkg::FLOAT_SER_POS]); // RULE10
    st_next.addrLoOe = !(st_next.state == quad_dac_pkg::H_IDLE
      && st_next.pinCtrl[quad_dac_pkg::FLOAT_ADR_POS]); // RULE15
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= quad_dac_pkg::HOST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign readdata = st_reg.rdData;
  assign link.csN = st_reg.csN;
  assign link.sclk = st_reg.sclk;
  assign link.sdiOut = st_reg.sdi;
  assign link.sdiOe = st_reg.sdiOe;
  assign link.converterLoadStrobeN = st_reg.loadN;
  assign link.registerClearN = st_reg.clearN;
  assign link.wrN = st_reg.wrN;
  assign link.channelAddrHi = st_reg.addrHi;
  assign link.addrLoOut = st_reg.addrLo;
  assign link.addrLoOe = st_reg.addrLoOe;
  assign link.parData = st_reg.parData;

endmodule

// [quad_dac_link_if.sv]
/*
  Pin-level link between controller and converter load logic.
  Assumes the controller owns every pin; floated lines are
  resolved here from the output enables.
*/
interface quad_dac_link_if;
  // Serial front end
  logic csN;
  logic sclk;
  logic sdiOut;
  logic sdiOe;
  logic serialInOrPowerDown;
  logic serialFloat;
  // Load and clear strobes
  logic converterLoadStrobeN;
  logic registerClearN;
  // Parallel front end
  logic wrN;
  logic channelAddrHi;
  logic addrLoOut;
  logic addrLoOe;
  logic channelAddrLoOrPowerDown;
  logic addrLoFloat;
  logic [7:0] parData;

  // Floated line rests low; the float sense stands for the window detector
  assign serialInOrPowerDown = sdiOe & sdiOut;
  assign serialFloat = ~sdiOe;
  assign channelAddrLoOrPowerDown = addrLoOe & addrLoOut;
  assign addrLoFloat = ~addrLoOe;

  modport host (
    output csN, sclk, sdiOut, sdiOe, converterLoadStrobeN, registerClearN,
    output wrN, channelAddrHi, addrLoOut, addrLoOe, parData
  );

  modport dev (
    input csN, sclk, serialInOrPowerDown, serialFloat, converterLoadStrobeN,
    input registerClearN, wrN, channelAddrHi, channelAddrLoOrPowerDown,
    input addrLoFloat, parData
  );
endinterface

// [quad_dac_load_control.sv]
/*
  Converter-side load logic: serial and parallel front ends,
  four input registers, four converter registers, power-down.
  Assumes every link pin is asynchronous to core_clk and is
  caught by a two-stage synchroniser before any use.
*/
module quad_dac_load_control (
  // Core clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Link from the controller
  quad_dac_link_if.dev link,
  // Converter codes and output driver enables
  output logic [3:0][7:0] dacCode,
  output logic [3:0][7:0] inputCode,
  output logic [3:0] chanDrive,
  output logic [3:0] chanOff,
  output logic hardwarePowerDown
);

  // ***********************************************************
  // State
  // ***********************************************************
  quad_dac_pkg::dev_s st_reg;
  quad_dac_pkg::dev_s st_next;
  quad_dac_pkg::link_pins_s pinsRaw;

  // ***********************************************************
  // Pin gathering
  // ***********************************************************
  // Bundle every pin so one synchroniser covers them all
  always_comb begin
    pinsRaw.csN = link.csN;
    pinsRaw.sclk = link.sclk;
    pinsRaw.serialInOrPowerDown = link.serialInOrPowerDown;
    pinsRaw.serialFloat = link.serialFloat;
    pinsRaw.converterLoadStrobeN = link.converterLoadStrobeN;
    pinsRaw.registerClearN = link.registerClearN;
    pinsRaw.wrN = link.wrN;
    pinsRaw.channelAddrHi = link.channelAddrHi;
    pinsRaw.channelAddrLoOrPowerDown = link.channelAddrLoOrPowerDown;
    pinsRaw.addrLoFloat = link.addrLoFloat;
    pinsRaw.parData = link.parData; // Bit 7 top line, bit 0 bottom
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  // All pin behaviour is judged on the second sync stage only
  always_comb begin
    quad_dac_pkg::link_pins_s cur;
    quad_dac_pkg::link_pins_s old;
    logic clkRise;
    logic selRise;
    logic [3:0] serSel;
    logic [3:0] parSel;
    logic powerDown;
    cur = st_reg.syncB;
    old = st_reg.prev;
    clkRise = 1'b0;
    selRise = 1'b0;
    serSel = 4'h0;
    parSel = 4'h0;
    powerDown = 1'b0;
    st_next = st_reg;

    // Synchroniser chain; first stage feeds only the second
    st_next.syncA = pinsRaw;
    st_next.syncB = st_reg.syncA;
    st_next.prev = st_reg.syncB;

    // Edge detection on synchronised levels
    clkRise = cur.sclk & ~old.sclk;
    selRise = cur.csN & ~old.csN;

    // Shift only while selected; MSB arrives first, so shift left
    if (!cur.csN && clkRise) begin // RULE5
      st_next.shiftWord = {st_reg.shiftWord[quad_dac_pkg::WORD_W - 2:0],
        cur.serialInOrPowerDown}; // RULE8 RULE9
    end

    // Deselect edge: last twelve bits decide target and off bits
    if (selRise) begin // RULE6
      serSel = quad_dac_pkg::chanDecode(
        st_reg.shiftWord[quad_dac_pkg::ADDR_HI_POS:quad_dac_pkg::ADDR_LO_POS]
      ); // RULE17 RULE18
      for (int i = 0; i < 4; i++) begin
        if (serSel[i]) begin
          st_next.inputCode[i] = st_reg.shiftWord[7:0];
        end
      end
      // Data still lands while off; output just stays undriven
      if (!st_reg.shiftWord[quad_dac_pkg::ALL_OFF_POS]) begin
        st_next.chanOff = quad_dac_pkg::CHAN_ALL; // RULE19
      end else if (!st_reg.shiftWord[quad_dac_pkg::SEL_OFF_POS]) begin
        st_next.chanOff = serSel; // RULE19
      end else begin
        st_next.chanOff = quad_dac_pkg::CHAN_NONE;
      end
    end

    // Parallel write: follow the bus while low, hold after the rise
    if (!cur.wrN) begin // RULE13 RULE20
      parSel = quad_dac_pkg::chanDecode(
        {cur.channelAddrHi, cur.channelAddrLoOrPowerDown}
      ); // RULE14 RULE17
      for (int i = 0; i < 4; i++) begin
        if (parSel[i]) begin
          st_next.inputCode[i] = cur.parData; // RULE16
        end
      end
    end

    // Load strobe is a level: transparent while low, no chip select term
    if (!cur.converterLoadStrobeN) begin // RULE1 RULE2 RULE7
      st_next.convCode = st_next.inputCode;
    end

    // Clear wins over every write and load; shift word untouched
    if (!cur.registerClearN) begin // RULE3 RULE4
      for (int i = 0; i < 4; i++) begin
        st_next.inputCode[i] = quad_dac_pkg::ZERO_CODE;
        st_next.convCode[i] = quad_dac_pkg::ZERO_CODE;
      end
    end

    // Floated serial or low address line forces all drivers off
    powerDown = cur.serialFloat | cur.addrLoFloat; // RULE10 RULE15
    // Power-down gates drivers only; codes are kept as they are
    st_next.outDrive = ~(st_next.chanOff
      | {4{powerDown}}); // RULE11 RULE12
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  // Reset stands for power-up: all codes zero, pins seen idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= quad_dac_pkg::DEV_RST; // RULE21
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // All from flip-flops; hardwarePowerDown is an OR of two synchronised bits
  assign dacCode = st_reg.convCode;
  assign inputCode = st_reg.inputCode;
  assign chanDrive = st_reg.outDrive;
  assign chanOff = st_reg.chanOff;
  assign hardwarePowerDown = st_reg.syncB.serialFloat | st_reg.syncB.addrLoFloat;

endmodule

// [quad_dac_monitor.sv]
/*
  Concurrent checks on the link between controller and converter logic.
  Assumes it sees the controller-side link signals and the converter outputs.
*/
// ***********************************************************
// Link and converter checker
// ***********************************************************
module quad_dac_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Link pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdiOut,
  input wire logic sdiOe,
  input wire logic converterLoadStrobeN,
  input wire logic registerClearN,
  input wire logic wrN,
  input wire logic addrLoOe,
  // Converter outputs
  input wire logic [3:0][7:0] dacCode,
  input wire logic [3:0][7:0] inputCode,
  input wire logic [3:0] chanDrive,
  input wire logic hardwarePowerDown
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic sclkPrev;
    logic [4:0] rises;
  } mon_s;
  mon_s mon_reg;
  mon_s mon_next;

  // Rising serial clocks since chip select fell
  always_comb begin
    mon_next = mon_reg;
    mon_next.sclkPrev = sclk;
    if (csN) mon_next.rises = 5'h00;
    else if (sclk && !mon_reg.sclkPrev) mon_next.rises = mon_reg.rises + 5'h01;
  end

  // Counter cleared with the design so a second reset starts clean
  always_ff @(posedge core_clk) begin
    if (srst) mon_reg <= '0;
    else mon_reg <= mon_next;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Five cycles cover the three-stage pin latency with margin; drive_off_a uses four, no margin
  clear_zero_a: assert property ((!registerClearN)[*5] |-> inputCode == '0 && dacCode == '0)
    else $error("clear did not zero the codes");
  load_transparent_a: assert property ((!converterLoadStrobeN && registerClearN)[*5]
    |-> dacCode == inputCode) else $error("converter code not following input code");
  load_hold_a: assert property ((converterLoadStrobeN && registerClearN)[*5]
    |=> $stable(dacCode)) else $error("converter code moved with load high");
  inputs_hold_a: assert property ((csN && wrN && registerClearN)[*5]
    |=> $stable(inputCode)) else $error("input code moved with no write");
  drive_off_a: assert property ((!sdiOe || !addrLoOe)[*4]
    |-> chanDrive == 4'h0 && hardwarePowerDown) else $error("drivers on while floated");
  pd_keeps_a: assert property ($rose(hardwarePowerDown) |-> $stable(dacCode))
    else $error("power-down changed converter code");
  sclk_data_a: assert property ($rose(sclk) |-> $stable(sdiOut) && !csN)
    else $error("serial data moved at clock rise");
  sclk_half_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("serial clock high phase wrong");
  frame_bits_a: assert property ($rose(csN) |-> mon_reg.rises == 5'h0C)
    else $error("frame did not carry twelve bits");
endmodule

// [quad_dac_pkg.sv]
/*
  Shared constants, pin bundle, state layouts and channel decode
  for the quad converter load logic and its controller.
  Assumes both ends run on one 100 MHz core clock.
*/
// ***********************************************************
// Summary of operation
// (RULE1) Load strobe copies all four codes together
// (RULE2) Load strobe low keeps converter registers transparent
// (RULE3) Clear zeroes input and converter registers
// (RULE4) Clear leaves the shift register alone
// (RULE5) Chip select high ignores serial clock
// (RULE6) Chip select rise writes addressed input register
// (RULE7) Chip select never touches converter loading
// (RULE8) One bit shifted per rising serial clock
// (RULE9) Host sends words most significant bit first
// (RULE10) Floated serial line gives hardware power-down
// (RULE11) Power-down keeps converter register contents
// (RULE12) Power-down turns channel drivers off
// (RULE13) Write strobe low writes parallel bus
// (RULE14) Two address inputs pick the register
// (RULE15) Floated low address gives hardware power-down
// (RULE16) Top data line is most significant
// (RULE17) Address 00 A, 01 B, 10 C, 11 D
// (RULE18) Twelve-bit word, last twelve bits used
// (RULE19) Low off bits shut all or addressed channel
// (RULE20) Write strobe low transparent, rising edge latches
// (RULE21) Power-up holds all codes at zero
// ***********************************************************
package quad_dac_pkg;

  // ***********************************************************
  // Word layout and codes
  // ***********************************************************
  localparam int WORD_W = 12;
  localparam int ALL_OFF_POS = 11;
  localparam int SEL_OFF_POS = 10;
  localparam int ADDR_HI_POS = 9;
  localparam int ADDR_LO_POS = 8;
  localparam logic [7:0] ZERO_CODE = 8'h00;
  localparam logic [1:0] CHAN_A = 2'h0;
  localparam logic [1:0] CHAN_B = 2'h1;
  localparam logic [1:0] CHAN_C = 2'h2;
  localparam logic [3:0] CHAN_ALL = 4'hF;
  localparam logic [3:0] CHAN_NONE = 4'h0;

  // ***********************************************************
  // Timing of the controller-made link clock
  // ***********************************************************
  localparam int CORE_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 80;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / CORE_PERIOD_NS);
  localparam logic [3:0] HALF_M1 = SCLK_HALF_CYC - 4'h1;
  localparam logic [3:0] LAST_BIT = 4'(WORD_W - 1);

  // ***********************************************************
  // Controller register map and fields
  // ***********************************************************
  localparam logic [3:0] REG_SER_WORD = 4'h0;
  localparam logic [3:0] REG_PAR_WORD = 4'h4;
  localparam logic [3:0] REG_PIN_CTRL = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int LOAD_POS = 0;
  localparam int CLEAR_POS = 1;
  localparam int FLOAT_SER_POS = 2;
  localparam int FLOAT_ADR_POS = 3;
  localparam logic [3:0] PIN_CTRL_RST = 4'h3;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef struct packed {
    logic csN;
    logic sclk;
    logic serialInOrPowerDown;
    logic serialFloat;
    logic converterLoadStrobeN;
    logic registerClearN;
    logic wrN;
    logic channelAddrHi;
    logic channelAddrLoOrPowerDown;
    logic addrLoFloat;
    logic [7:0] parData;
  } link_pins_s;

  localparam link_pins_s PINS_IDLE = '{csN: 1'b1, sclk: 1'b0,
    serialInOrPowerDown: 1'b0, serialFloat: 1'b0, converterLoadStrobeN: 1'b1,
    registerClearN: 1'b1, wrN: 1'b1, channelAddrHi: 1'b0,
    channelAddrLoOrPowerDown: 1'b0, addrLoFloat: 1'b0, parData: 8'h00};

  typedef struct packed {
    link_pins_s syncA;
    link_pins_s syncB;
    link_pins_s prev;
    logic [11:0] shiftWord;
    logic [3:0][7:0] inputCode;
    logic [3:0][7:0] convCode;
    logic [3:0] chanOff;
    logic [3:0] outDrive;
  } dev_s;

  localparam dev_s DEV_RST = '{syncA: PINS_IDLE, syncB: PINS_IDLE,
    prev: PINS_IDLE, shiftWord: 12'h000, inputCode: '0, convCode: '0,
    chanOff: 4'h0, outDrive: 4'hF};

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_SER_LO = 7'h02,
    H_SER_HI = 7'h04,
    H_SER_END = 7'h08,
    H_PAR_SET = 7'h10,
    H_PAR_WR = 7'h20,
    H_PAR_HOLD = 7'h40
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [3:0] cnt;
    logic [3:0] bitsLeft;
    logic [11:0] word;
    logic csN;
    logic sclk;
    logic sdi;
    logic sdiOe;
    logic loadN;
    logic clearN;
    logic wrN;
    logic addrHi;
    logic addrLo;
    logic addrLoOe;
    logic [7:0] parData;
    logic [3:0] pinCtrl;
    logic rdDone;
    logic [31:0] rdData;
  } host_s;

  localparam host_s HOST_RST = '{state: H_IDLE, cnt: 4'h0, bitsLeft: 4'h0,
    word: 12'h000, csN: 1'b1, sclk: 1'b0, sdi: 1'b0, sdiOe: 1'b1,
    loadN: 1'b1, clearN: 1'b1, wrN: 1'b1, addrHi: 1'b0, addrLo: 1'b0,
    addrLoOe: 1'b1, parData: 8'h00, pinCtrl: PIN_CTRL_RST, rdDone: 1'b0,
    rdData: 32'h0000_0000};

  // Address pair to one-hot channel select
  function automatic logic [3:0] chanDecode(input logic [1:0] addr);
    case (addr)
      CHAN_A: chanDecode = 4'h1;
      CHAN_B: chanDecode = 4'h2;
      CHAN_C: chanDecode = 4'h4;
      default: chanDecode = 4'h8;
    endcase
  endfunction

endpackage

// [testbench.sv]
/*
  Self-checking bench: controller and converter logic joined by the link.
  Assumes the Avalon timing and register map of the controller.
*/
// ***********************************************************
// Bench top
// ***********************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic srst;
  logic ce;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0][7:0] dacCode;
  logic [3:0][7:0] inputCode;
  logic [3:0] chanDrive;
  logic [3:0] chanOff;
  logic hardwarePowerDown;
  logic [3:0][7:0] expInput;
  logic [3:0][7:0] expDac;
  logic [31:0] rngState;
  logic [31:0] rdWord;
  logic [11:0] w;
  logic [7:0] code;
  logic [1:0] ch;
  int errors = 0;
  int samplesChecked = 0;
  int cycles = 0;

  quad_dac_link_if i_quad_dac_link_if ();
  quad_dac_host_ctrl i_quad_dac_host_ctrl (.core_clk(core_clk), .srst(srst), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(i_quad_dac_link_if.host));
  quad_dac_load_control i_quad_dac_load_control (.core_clk(core_clk), .srst(srst),
    .ce(ce), .link(i_quad_dac_link_if.dev), .dacCode(dacCode), .inputCode(inputCode),
    .chanDrive(chanDrive), .chanOff(chanOff), .hardwarePowerDown(hardwarePowerDown));
  quad_dac_monitor i_quad_dac_monitor (.core_clk(core_clk), .srst(srst),
    .csN(i_quad_dac_link_if.csN), .sclk(i_quad_dac_link_if.sclk),
    .sdiOut(i_quad_dac_link_if.sdiOut), .sdiOe(i_quad_dac_link_if.sdiOe),
    .converterLoadStrobeN(i_quad_dac_link_if.converterLoadStrobeN),
    .registerClearN(i_quad_dac_link_if.registerClearN), .wrN(i_quad_dac_link_if.wrN),
    .addrLoOe(i_quad_dac_link_if.addrLoOe), .dacCode(dacCode), .inputCode(inputCode),
    .chanDrive(chanDrive), .hardwarePowerDown(hardwarePowerDown));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] next_rand();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  // Low off bits: all-off wins, else only the addressed channel
  function automatic logic [3:0] off_mask(input logic [11:0] wd);
    if (!wd[11]) return 4'hF;
    if (!wd[10]) return 4'h1 << wd[9:8];
    return 4'h0;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_code(input string name, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic check_all();
    for (int k = 0; k < 4; k++) begin
      check_code("input code", expInput[k], inputCode[k]);
      check_code("converter code", expDac[k], dacCode[k]);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_access(input logic rd, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    // Looked at before the edge's updates land, so these are the taken values
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rdWord = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // One idle edge so the next request never reassigns a strobe at once
    @(posedge core_clk);
  endtask

  // Poll busy, then allow the three-edge pin latency
  task automatic wait_idle();
    for (int n = 0; n < 200; n++) begin
      bus_access(1'b1, quad_dac_pkg::REG_STATUS, 32'h0);
      if (rdWord[0] === 1'b0) break;
    end
    repeat (4) @(posedge core_clk);
  endtask

  task automatic set_pins(input logic [3:0] v);
    bus_access(1'b0, quad_dac_pkg::REG_PIN_CTRL, {28'h0, v});
    repeat (6) @(posedge core_clk);
  endtask

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    rngState = 32'h0000_1F69;
    srst = 1'b1;
    ce = 1'b1;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    expInput = '0;
    expDac = '0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check_all();
    bus_access(1'b1, quad_dac_pkg::REG_PIN_CTRL, 32'h0);
    check_word("pin control", 32'h3, rdWord);
    bus_access(1'b0, 4'h2, 32'hFFFF_FFFF);
    bus_access(1'b1, 4'h2, 32'h0);
    check_word("unmapped read", 32'h0, rdWord);
    // Serial frames back to back, extreme codes on A and D
    for (int k = 0; k < 4; k++) begin
      ch = 2'(k);
      code = (k == 0) ? 8'h00 : (k == 3) ? 8'hFF : 8'(next_rand());
      bus_access(1'b0, quad_dac_pkg::REG_SER_WORD, {20'h0, 1'b1, 1'b1, ch, code});
      expInput[k] = code;
    end
    wait_idle();
    check_all();
    set_pins(4'h2);
    expDac = expInput;
    check_all();
    set_pins(4'h3);
    // Parallel writes, single top and bottom bits on A and B
    for (int k = 0; k < 4; k++) begin
      ch = 2'(k);
      code = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'(next_rand());
      bus_access(1'b0, quad_dac_pkg::REG_PAR_WORD, {22'h0, ch, code});
      expInput[k] = code;
    end
    wait_idle();
    check_all();
    // Write while load held low reaches the converter register
    set_pins(4'h2);
    code = 8'(next_rand());
    bus_access(1'b0, quad_dac_pkg::REG_PAR_WORD, {22'h0, 2'h2, code});
    expInput[2] = code;
    wait_idle();
    expDac = expInput;
    check_all();
    set_pins(4'h3);
    // Every pairing of the two off bits, random channel
    for (int k = 0; k < 4; k++) begin
      ch = 2'(next_rand());
      code = 8'(next_rand());
      w = {k[0], k[1], ch, code};
      bus_access(1'b0, quad_dac_pkg::REG_SER_WORD, {20'h0, w});
      expInput[ch] = code;
      wait_idle();
      check_word("channel off", {28'h0, off_mask(w)}, {28'h0, chanOff});
      check_word("driver on", {28'h0, ~off_mask(w)}, {28'h0, chanDrive});
      check_all();
    end
    // Float the serial line, then the low address line
    for (int k = 0; k < 2; k++) begin
      set_pins(k == 0 ? 4'h7 : 4'hB);
      check_word("power down", 32'h1, {31'h0, hardwarePowerDown});
      check_word("driver on", 32'h0, {28'h0, chanDrive});
      check_all();
      set_pins(4'h3);
      check_word("driver on", 32'hF, {28'h0, chanDrive});
    end
    set_pins(4'h1);
    expInput = '0;
    expDac = '0;
    check_all();
    set_pins(4'h3);
    complete_run();
  end
endmodule
